// ==== logic/dac_calibration_alarm_regs.sv ====
// Calibration, fault status, alarm mask and fault reaction register bank behind an AXI4-Lite slave
module dac_calibration_alarm_regs
  import dac_cal_alarm_pkg::*;
(
  input  wire logic           ref_clk_i,
  input  wire logic           rst_b_i,
  input  wire logic [7:0]     s_axi_awaddr_i,
  input  wire logic           s_axi_awvalid_i,
  output logic                s_axi_awready_o,
  input  wire logic [31:0]    s_axi_wdata_i,
  input  wire logic [3:0]     s_axi_wstrb_i,
  input  wire logic           s_axi_wvalid_i,
  output logic                s_axi_wready_o,
  output logic [1:0]          s_axi_bresp_o,
  output logic                s_axi_bvalid_o,
  input  wire logic           s_axi_bready_i,
  input  wire logic [7:0]     s_axi_araddr_i,
  input  wire logic           s_axi_arvalid_i,
  output logic                s_axi_arready_o,
  output logic [31:0]         s_axi_rdata_o,
  output logic [1:0]          s_axi_rresp_o,
  output logic                s_axi_rvalid_o,
  input  wire logic           s_axi_rready_i,
  input  wire fault_in_type   fault_i,
  output cal_out_type         cal_o,
  output action_out_type      action_o,
  output logic                alarm_o
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  fault_in_type sync_stage;
  fault_in_type fault_sync;

  // Stage one feeds stage two only; conditions come from the analog clockless side
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_stage <= '0;
      fault_sync <= '0;
    end else begin
      sync_stage <= fault_i;
      fault_sync <= sync_stage;
    end
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic        calibration_on;
  logic [15:0] user_gain_word;
  logic [15:0] user_offset_word;
  logic        learn_done_flag;
  logic        watchdog_fault_flag;
  logic        crc_error_flag;
  logic [15:0] alarm_pin_masks;
  logic [7:0]  fault_response_select;
  logic [5:0]  user_alarm_value;
  logic        user_toggle_bit;
  logic        shutdown_latch;

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic        aw_held;
  logic [5:0]  aw_index;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire         aw_take     = s_axi_awvalid_i & s_axi_awready_o;
  wire         w_take      = s_axi_wvalid_i & s_axi_wready_o;
  wire         wr_fire     = aw_held & w_held & ~s_axi_bvalid_o;
  wire         next_aw_held = (aw_held | aw_take) & ~wr_fire;
  wire         next_w_held  = (w_held | w_take) & ~wr_fire;
  wire         b_done      = s_axi_bvalid_o & s_axi_bready_i;
  wire         next_bvalid = wr_fire | (s_axi_bvalid_o & ~b_done);

  // Write decode with byte lanes; only the low two lanes carry register bits
  wire [15:0]  lane_mask   = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [15:0]  wr_bits     = w_data[15:0] & lane_mask;
  wire         wr_cal_en   = wr_fire & (aw_index == CAL_ENABLE_IDX);
  wire         wr_gain     = wr_fire & (aw_index == USER_GAIN_IDX);
  wire         wr_offset   = wr_fire & (aw_index == USER_OFFSET_IDX);
  wire         wr_flags    = wr_fire & (aw_index == FAULT_FLAGS_IDX);
  wire         wr_mask     = wr_fire & (aw_index == ALARM_MASK_IDX);
  wire         wr_resp     = wr_fire & (aw_index == RESPONSE_SEL_IDX);
  wire         wr_value    = wr_fire & (aw_index == ALARM_VALUE_IDX);
  wire         wr_toggle   = wr_fire & (aw_index == TOGGLE_CTRL_IDX);
  wire         wr_mapped   = wr_cal_en | wr_gain | wr_offset | wr_flags | wr_mask | wr_resp | wr_value | wr_toggle;
  wire         toggle_wr_val = w_data[USER_TOGGLE_POS];

  // Address and data are accepted independently and held until the pair is complete
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_index        <= 6'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
    end else begin
      aw_held         <= next_aw_held;
      w_held          <= next_w_held;
      s_axi_awready_o <= ~next_aw_held;
      s_axi_wready_o  <= ~next_w_held;
      s_axi_bvalid_o  <= next_bvalid;
      if (aw_take) begin
        aw_index <= s_axi_awaddr_i[7:2];
      end
      if (w_take) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        s_axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status word and alarm logic
  // ----------------------------------------------------------------
  wire         open_ind     = fault_sync.open_circuit;
  wire         short_ind    = fault_sync.short_circuit;
  wire         channel_ind  = fault_sync.channel_fault | open_ind | short_ind;
  // Sticky flags: a set in the clearing cycle wins over write-one-to-clear
  wire [15:0]  clear_bits   = wr_flags ? wr_bits : 16'h0000;
  wire         next_learn   = fault_sync.learn_done | (learn_done_flag & ~clear_bits[LEARN_DONE_BIT]);
  wire         next_wdt     = fault_sync.watchdog_expire | (watchdog_fault_flag & ~clear_bits[WATCHDOG_BIT]);
  wire         next_crc     = fault_sync.crc_error | (crc_error_flag & ~clear_bits[CRC_BIT]);

  logic [15:0] fault_condition_flags;
  always_comb begin
    fault_condition_flags                  = 16'h0000;
    fault_condition_flags[LEARN_DONE_BIT]  = learn_done_flag;
    fault_condition_flags[WATCHDOG_BIT]    = watchdog_fault_flag;
    fault_condition_flags[SUPPLY_GOOD_BIT] = fault_sync.supply_good;
    fault_condition_flags[TOGGLE_BIT]      = user_toggle_bit;
    fault_condition_flags[CRC_BIT]         = crc_error_flag;
    fault_condition_flags[HEAT_BIT]        = fault_sync.over_temp;
    fault_condition_flags[CHANNEL_BIT]     = channel_ind;
  end

  // Unmasked flags drive the pin; bits 11, 5, 4 and 0 are the only alarm sources
  wire [15:0]  alarm_open   = fault_condition_flags & ~alarm_pin_masks & ALARM_SOURCES;
  wire         next_alarm   = |alarm_open;

  // Reaction fields; the invalid code is treated as no action
  fault_action_type act_crc_wdt;
  fault_action_type act_open;
  fault_action_type act_short;
  fault_action_type act_heat;
  assign act_crc_wdt = fault_action_type'(fault_response_select[ACT_CRC_WDT_LSB +: 2]);
  assign act_open    = fault_action_type'(fault_response_select[ACT_OPEN_LSB +: 2]);
  assign act_short   = fault_action_type'(fault_response_select[ACT_SHORT_LSB +: 2]);
  assign act_heat    = fault_action_type'(fault_response_select[ACT_HEAT_LSB +: 2]);

  wire         crc_wdt_cond = crc_error_flag | watchdog_fault_flag;
  wire         heat_cond    = fault_sync.over_temp;
  // Single channel: the initiating output and all outputs are the same output
  wire         next_force   = (crc_wdt_cond & (act_crc_wdt == ACT_CODE)) |
                              (open_ind & (act_open == ACT_CODE)) |
                              (short_ind & (act_short == ACT_CODE)) |
                              (heat_cond & (act_heat == ACT_CODE));
  wire         trip         = (crc_wdt_cond & (act_crc_wdt == ACT_SHUTDOWN)) |
                              (open_ind & (act_open == ACT_SHUTDOWN)) |
                              (short_ind & (act_short == ACT_SHUTDOWN)) |
                              (heat_cond & (act_heat == ACT_SHUTDOWN));
  // Shutdown survives the condition going away; only reset releases it
  wire         next_shutdown = shutdown_latch | trip;

  // Software registers, status flags and reaction state
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      calibration_on        <= 1'b0;
      user_gain_word        <= USER_GAIN_RST;
      user_offset_word      <= USER_OFFSET_RST;
      learn_done_flag       <= FAULT_FLAGS_RST[LEARN_DONE_BIT];
      watchdog_fault_flag   <= FAULT_FLAGS_RST[WATCHDOG_BIT];
      crc_error_flag        <= FAULT_FLAGS_RST[CRC_BIT];
      alarm_pin_masks       <= ALARM_MASK_RST;
      fault_response_select <= RESPONSE_RST;
      user_alarm_value      <= ALARM_VALUE_RST;
      user_toggle_bit       <= 1'b0;
      shutdown_latch        <= 1'b0;
    end else begin
      if (wr_cal_en) calibration_on <= wr_bits[CAL_ON_BIT] | (calibration_on & ~lane_mask[CAL_ON_BIT]);
      if (wr_gain) user_gain_word <= wr_bits | (user_gain_word & ~lane_mask);
      if (wr_offset) user_offset_word <= wr_bits | (user_offset_word & ~lane_mask);
      if (wr_mask) alarm_pin_masks <= wr_bits | (alarm_pin_masks & ~lane_mask);
      if (wr_resp && w_strb[0]) fault_response_select <= w_data[7:0];
      if (wr_value && w_strb[1]) user_alarm_value <= w_data[ALARM_VALUE_LSB +: 6];
      if (wr_toggle && w_strb[0]) user_toggle_bit <= w_data[USER_TOGGLE_POS];
      learn_done_flag     <= next_learn;
      watchdog_fault_flag <= next_wdt;
      crc_error_flag      <= next_crc;
      shutdown_latch      <= next_shutdown;
    end
  end

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  // Gated words: the data path sees zero gain and offset trims while disabled
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cal_o    <= '0;
      action_o <= '0;
      alarm_o  <= 1'b0;
    end else begin
      cal_o.calibration_on   <= calibration_on;
      cal_o.user_gain_word   <= calibration_on ? user_gain_word : 16'h0000;
      cal_o.user_offset_word <= calibration_on ? user_offset_word : 16'h0000;
      action_o.force_code       <= next_force & ~next_shutdown;
      action_o.user_alarm_value <= user_alarm_value;
      action_o.shutdown         <= next_shutdown;
      alarm_o                   <= next_alarm;
    end
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  wire         ar_take   = s_axi_arvalid_i & s_axi_arready_o;
  wire [5:0]   ar_index  = s_axi_araddr_i[7:2];
  wire         r_done    = s_axi_rvalid_o & s_axi_rready_i;
  wire         next_rvalid = ar_take | (s_axi_rvalid_o & ~r_done);

  logic [15:0] rd_word;
  logic        rd_hit;
  always_comb begin
    rd_word = 16'h0000;
    rd_hit  = 1'b1;
    unique case (ar_index)
      CAL_ENABLE_IDX:   rd_word[CAL_ON_BIT] = calibration_on;
      USER_GAIN_IDX:    rd_word = user_gain_word;
      USER_OFFSET_IDX:  rd_word = user_offset_word;
      FAULT_FLAGS_IDX:  rd_word = fault_condition_flags;
      ALARM_MASK_IDX:   rd_word = alarm_pin_masks;
      RESPONSE_SEL_IDX: rd_word[7:0] = fault_response_select;
      ALARM_VALUE_IDX:  rd_word[ALARM_VALUE_LSB +: 6] = user_alarm_value;
      TOGGLE_CTRL_IDX:  rd_word[USER_TOGGLE_POS] = user_toggle_bit;
      default:          rd_hit = 1'b0;
    endcase
  end

  // One read at a time; data is captured on the address handshake
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= RESP_OKAY;
    end else begin
      s_axi_arready_o <= ~next_rvalid;
      s_axi_rvalid_o  <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata_o <= {16'h0000, rd_word};
        s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_GAIN_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_gain && (w_strb[1:0] == 2'b11) |=> user_gain_word == $past(wr_bits))
    else $error("gain word not stored");

  AST_OFFSET_WRITE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_offset && (w_strb[1:0] == 2'b11) |=> user_offset_word == $past(wr_bits))
    else $error("offset word not stored");

  AST_OFFSET_READ: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ar_take && ar_index == USER_OFFSET_IDX |=> s_axi_rdata_o == {16'h0000, $past(user_offset_word)})
    else $error("offset readback wrong");

  AST_LEARN_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    learn_done_flag && !clear_bits[LEARN_DONE_BIT] |=> learn_done_flag)
    else $error("learn flag lost without clear");

  AST_LEARN_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    clear_bits[LEARN_DONE_BIT] && !fault_sync.learn_done |=> !learn_done_flag)
    else $error("learn flag survived its clear");

  AST_WDT_SET_WINS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    fault_sync.watchdog_expire |=> watchdog_fault_flag)
    else $error("watchdog flag missed");

  AST_CRC_SET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(fault_sync.crc_error) |=> crc_error_flag)
    else $error("crc flag not set after input");

  AST_WDT_ALARM: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    watchdog_fault_flag && !alarm_pin_masks[WATCHDOG_BIT] |=> alarm_o)
    else $error("unmasked watchdog missed alarm pin");

  AST_CRC_ALARM: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    crc_error_flag && !alarm_pin_masks[CRC_BIT] |=> alarm_o)
    else $error("unmasked crc error missed alarm pin");

  AST_CHANNEL_ALARM: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    channel_ind && !alarm_pin_masks[CHANNEL_BIT] |=> alarm_o)
    else $error("unmasked channel fault missed alarm pin");

  AST_MASKED_WDT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    alarm_pin_masks[WATCHDOG_BIT] && !(crc_error_flag && !alarm_pin_masks[CRC_BIT]) &&
    !(fault_sync.over_temp && !alarm_pin_masks[HEAT_BIT]) && !(channel_ind && !alarm_pin_masks[CHANNEL_BIT])
    |=> !alarm_o)
    else $error("masked watchdog reached alarm pin");

  AST_ALARM_HEAT: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    fault_sync.over_temp && !alarm_pin_masks[HEAT_BIT] |=> alarm_o)
    else $error("unmasked heat missed alarm pin");

  AST_ALARM_PIN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 alarm_o == |($past(fault_condition_flags) & ~$past(alarm_pin_masks) & ALARM_SOURCES))
    else $error("alarm pin disagrees with unmasked flags");

  AST_SHUTDOWN_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    action_o.shutdown |=> action_o.shutdown [*4])
    else $error("shutdown released before reset");

  AST_OPEN_TRIP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    open_ind && act_open == ACT_SHUTDOWN |=> action_o.shutdown)
    else $error("open circuit shutdown not applied");

  AST_SHORT_CODE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    short_ind && act_short == ACT_CODE |=> action_o.force_code || action_o.shutdown)
    else $error("short circuit code not forced");

  AST_HEAT_TRIP: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    heat_cond && act_heat == ACT_SHUTDOWN |=> action_o.shutdown && !action_o.force_code)
    else $error("heat shutdown not applied");

  AST_CODE_VALUE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    ##1 action_o.user_alarm_value == $past(user_alarm_value))
    else $error("alarm code output differs from register");

  AST_CAL_GATE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !$past(calibration_on) |-> cal_o.user_gain_word == 16'h0000 && cal_o.user_offset_word == 16'h0000)
    else $error("calibration applied while disabled");

  AST_TOGGLE_MIRROR: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_toggle && w_strb[0] |=> fault_condition_flags[TOGGLE_BIT] == $past(toggle_wr_val))
    else $error("toggle mirror differs");

  AST_BAD_INDEX: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_fire && !wr_mapped |=> s_axi_bresp_o == RESP_SLVERR)
    else $error("unmapped write not refused");

endmodule

// ==== logic/dac_cal_alarm_pkg.sv ====
// Package: register map, field positions, reset values and carrier types of the calibration and alarm bank
package dac_cal_alarm_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [5:0] CAL_ENABLE_IDX   = 6'h08;
  localparam logic [5:0] USER_GAIN_IDX    = 6'h09;
  localparam logic [5:0] USER_OFFSET_IDX  = 6'h0a;
  localparam logic [5:0] FAULT_FLAGS_IDX  = 6'h0b;
  localparam logic [5:0] ALARM_MASK_IDX   = 6'h0c;
  localparam logic [5:0] RESPONSE_SEL_IDX = 6'h0d;
  localparam logic [5:0] ALARM_VALUE_IDX  = 6'h0e;
  localparam logic [5:0] TOGGLE_CTRL_IDX  = 6'h11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] USER_GAIN_RST   = 16'h0000;
  localparam logic [15:0] USER_OFFSET_RST = 16'h0000;
  localparam logic [15:0] FAULT_FLAGS_RST = 16'h1000;
  localparam logic [15:0] ALARM_MASK_RST  = 16'h0000;
  localparam logic [7:0]  RESPONSE_RST    = 8'h00;
  localparam logic [5:0]  ALARM_VALUE_RST = 6'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LEARN_DONE_BIT   = 12;
  localparam int WATCHDOG_BIT     = 11;
  localparam int SUPPLY_GOOD_BIT  = 7;
  localparam int TOGGLE_BIT       = 6;
  localparam int CRC_BIT          = 5;
  localparam int HEAT_BIT         = 4;
  localparam int CHANNEL_BIT      = 0;
  localparam int CAL_ON_BIT       = 0;
  localparam int USER_TOGGLE_POS  = 0;
  localparam int ALARM_VALUE_LSB  = 10;
  localparam int ACT_CRC_WDT_LSB  = 6;
  localparam int ACT_OPEN_LSB     = 4;
  localparam int ACT_SHORT_LSB    = 2;
  localparam int ACT_HEAT_LSB     = 0;

  // Flags that can reach the alarm pin
  localparam logic [15:0] ALARM_SOURCES = 16'h0831;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Per-class fault reaction
  typedef enum logic [1:0] {
    ACT_NONE     = 2'b00,
    ACT_CODE     = 2'b01,
    ACT_SHUTDOWN = 2'b10,
    ACT_INVALID  = 2'b11
  } fault_action_type;

  // Conditions arriving from the analog side
  typedef struct packed {
    logic learn_done;
    logic watchdog_expire;
    logic supply_good;
    logic crc_error;
    logic over_temp;
    logic channel_fault;
    logic open_circuit;
    logic short_circuit;
  } fault_in_type;

  // Calibration words handed to the data path
  typedef struct packed {
    logic        calibration_on;
    logic [15:0] user_gain_word;
    logic [15:0] user_offset_word;
  } cal_out_type;

  // Reaction commands to the converter and supply
  typedef struct packed {
    logic       force_code;
    logic [5:0] user_alarm_value;
    logic       shutdown;
  } action_out_type;

endpackage

// ==== sim/dac_calibration_alarm_regs_tb.sv ====
// Self-checking bench for the calibration, status, mask and fault reaction bank
module dac_calibration_alarm_regs_tb
  import dac_cal_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic           ref_clk_i, rst_b_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic           s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic           s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, alarm_o;
  logic [7:0]     s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0]    s_axi_wdata_i, s_axi_rdata_o, rd;
  logic [3:0]     s_axi_wstrb_i;
  logic [1:0]     s_axi_bresp_o, s_axi_rresp_o, rs;
  fault_in_type   fault_i;
  cal_out_type    cal_o;
  action_out_type action_o;
  cal_out_type    cal_s;
  action_out_type act_s;
  logic           al_s;
  int             err_total, compares;
  dac_calibration_alarm_regs dac_calibration_alarm_regs_i (.ref_clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .fault_i, .cal_o, .action_o, .alarm_o);
  // Clock at 40 MHz
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // Outputs copied mid-cycle so checks never race the edge that launches them
  always @(negedge ref_clk_i) begin
    cal_s <= cal_o;
    act_s <= action_o;
    al_s  <= alarm_o;
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e, input string m);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask
  // Bounded waits only: a stuck handshake ends the run
  task automatic tmo(input int n);
    if (n >= 200) begin
      err_total++;
      $display("BAD %0t bus gave no answer", $time);
      end_of_test;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Address and data offered together, each released once taken
  // Handshakes are judged from values seen mid-cycle, i.e. as the next rising edge samples them
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    int   n;
    logic aw_ok, w_ok, b_ok;
    n = 0;
    b_ok = 1'b0;
    s_axi_awaddr_i  <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    s_axi_wdata_i   <= {16'h0000, d};
    s_axi_wvalid_i  <= 1'b1;
    while (!b_ok) begin
      @(negedge ref_clk_i);
      aw_ok = s_axi_awvalid_i & (s_axi_awready_o === 1'b1);
      w_ok  = s_axi_wvalid_i & (s_axi_wready_o === 1'b1);
      b_ok  = (s_axi_bvalid_o === 1'b1);
      r     = s_axi_bresp_o;
      @(posedge ref_clk_i);
      n++;
      if (aw_ok) s_axi_awvalid_i <= 1'b0;
      if (w_ok) s_axi_wvalid_i <= 1'b0;
      tmo(n);
    end
    s_axi_bready_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic ar_ok, r_ok;
    n = 0;
    r_ok = 1'b0;
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    while (!r_ok) begin
      @(negedge ref_clk_i);
      ar_ok = s_axi_arvalid_i & (s_axi_arready_o === 1'b1);
      r_ok  = (s_axi_rvalid_o === 1'b1);
      d     = s_axi_rdata_o;
      r     = s_axi_rresp_o;
      @(posedge ref_clk_i);
      n++;
      if (ar_ok) s_axi_arvalid_i <= 1'b0;
      tmo(n);
    end
    s_axi_rready_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic do_reset;
    rst_b_i <= 1'b0;
    wt(20);
    rst_b_i <= 1'b1;
    wt(1);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdw(8'h2c, rd, rs); chk(rd, 32'h00001000, "status reset");
    rdw(8'h24, rd, rs); chk(rd, 32'h0, "gain reset");
    rdw(8'h28, rd, rs); chk(rd, 32'h0, "offset reset");
    rdw(8'h30, rd, rs); chk(rd, 32'h0, "mask reset");
    rdw(8'h34, rd, rs); chk(rd, 32'h0, "action reset");
    wr(8'h24, 16'ha55a, rs); wr(8'h28, 16'h5aa5, rs);
    rdw(8'h24, rd, rs); chk(rd, 32'h0000a55a, "gain readback");
    rdw(8'h28, rd, rs); chk(rd, 32'h00005aa5, "offset readback");
    chk(cal_s, 33'h0, "calibration off");
    wr(8'h20, 16'h0001, rs); wt(2);
    chk(cal_s, {1'b1, 16'ha55a, 16'h5aa5}, "calibration on");
    wr(8'hfc, 16'hffff, rs); chk(rs, RESP_SLVERR, "unmapped write");
    rdw(8'hfc, rd, rs); chk({rd, rs}, {32'h0, RESP_SLVERR}, "unmapped read");
    $display("test regs done");
  endtask
  task automatic t_flags;
    wr(8'h2c, 16'h1000, rs); rdw(8'h2c, rd, rs); chk(rd, 32'h0, "learn flag clear");
    fault_i <= 8'hfc; wt(4); wr(8'h44, 16'h0001, rs);
    rdw(8'h2c, rd, rs); chk(rd, 32'h000018f1, "all flags up");
    fault_i <= 8'h00; wt(4);
    rdw(8'h2c, rd, rs); chk(rd, 32'h00001860, "sticky flags");
    wr(8'h2c, 16'h1820, rs); wr(8'h44, 16'h0000, rs);
    rdw(8'h2c, rd, rs); chk(rd, 32'h0, "flags cleared");
    $display("test flags done");
  endtask
  task automatic t_mask;
    int mb[4] = '{11, 5, 4, 0};
    int ib[4] = '{6, 4, 3, 2};
    for (int i = 0; i < 4; i++) begin
      wr(8'h30, 16'h0001 << mb[i], rs); fault_i <= 8'h01 << ib[i]; wt(6);
      chk(al_s, 1'b0, "masked source");
      wr(8'h30, 16'h0000, rs); wt(1);
      chk(al_s, 1'b1, "unmasked source");
      fault_i <= 8'h00; wt(4); wr(8'h2c, 16'h0831, rs); wt(1);
      chk(al_s, 1'b0, "no source");
    end
    $display("test mask done");
  endtask
  task automatic t_action;
    int ib[4] = '{3, 0, 1, 4};
    wr(8'h38, 16'ha800, rs);
    for (int k = 0; k < 4; k++) begin
      wr(8'h34, 16'h0001 << (2 * k), rs); fault_i <= 8'h01 << ib[k]; wt(6);
      chk(act_s, {1'b1, 6'h2a, 1'b0}, "alarm code forced");
      fault_i <= 8'h00; wt(4); wr(8'h2c, 16'h0831, rs); wt(1);
      chk({act_s.force_code, act_s.shutdown}, 2'b00, "code released");
    end
    wr(8'h34, 16'h0003, rs); fault_i <= 8'h08; wt(4);
    chk({act_s.force_code, act_s.shutdown}, 2'b00, "invalid setting");
    wr(8'h34, 16'h0080, rs); fault_i <= 8'h10; wt(6);
    chk(act_s.shutdown, 1'b1, "shutdown taken");
    fault_i <= 8'h00; wt(4); wr(8'h2c, 16'h0831, rs); wt(2);
    chk(act_s.shutdown, 1'b1, "shutdown latched");
    do_reset;
    chk(act_s.shutdown, 1'b0, "shutdown reset");
    wr(8'h34, 16'h0002, rs); fault_i <= 8'h08; wt(4);
    chk(act_s.shutdown, 1'b1, "heat shutdown");
    $display("test action done");
  endtask
  // Main sequence
  initial begin
    rst_b_i = 1'b0; s_axi_awvalid_i = 1'b0; s_axi_wvalid_i = 1'b0; s_axi_bready_i = 1'b0;
    s_axi_arvalid_i = 1'b0; s_axi_rready_i = 1'b0; s_axi_awaddr_i = 8'h00; s_axi_araddr_i = 8'h00;
    s_axi_wdata_i = 32'h0; s_axi_wstrb_i = 4'hf; fault_i = 8'h00;
    err_total = 0; compares = 0;
    @(posedge ref_clk_i);
    do_reset;
    t_regs;
    t_flags;
    t_mask;
    t_action;
    end_of_test;
  end
endmodule
